/* logic/qsp_pkg.sv */
// package: register map, field positions, reset values and state types of the queued serial port
//****************************************************************
// Functional notes
// - tx flush bit empties transmit queue
// - rx flush bit empties receive queue
// - reset empties both queues
// - loopback ties tx to rx, rts to cts
// - fill count bits 14:8 hold tx bytes
// - fill count bits 6:0 hold rx bytes
// - counts read zero empty, sixty-four full
// - fill count bits 15 and 7 read zero
// - fill count read-only, resets to zero
// - stop count used only when halt enabled
// - halt after stop count plus one bytes
// - stop function only in asynchronous mode
// - stop count resets to all ones
// - separate sixty-four entry tx and rx queues
// - char length bit selects eight or seven
// - parity enable and stop length bits
// - detect framing, parity, overrun, full, ready, break
// - clock source selects generator or external clock
// - stop count reached sets halt flag, irq
// - start bit zero then data lsb first
//****************************************************************
package qsp_pkg;

  //****************************************************************
  // register offsets and field positions
  //****************************************************************
  localparam logic [4:0] REG_MODE    = 5'h00;
  localparam logic [4:0] REG_CTRL    = 5'h04;
  localparam logic [4:0] REG_STAT    = 5'h08;
  localparam logic [4:0] REG_DATA    = 5'h0C;
  localparam logic [4:0] REG_QCTL    = 5'h10;
  localparam logic [4:0] REG_FILL    = 5'h14;
  localparam logic [4:0] REG_STOP    = 5'h18;
  localparam logic [4:0] REG_DIV     = 5'h1C;

  localparam int MODE_SYNC   = 7;
  localparam int MODE_CHR    = 6;
  localparam int MODE_PAR    = 5;
  localparam int MODE_ODD    = 4;
  localparam int MODE_STOP2  = 3;
  localparam int CTRL_TXEN   = 5;
  localparam int CTRL_RXEN   = 4;
  localparam int CTRL_HALTIE = 2;
  localparam int CTRL_CKS_HI = 1;
  localparam int ST_HALT     = 0;
  localparam int ST_FER      = 1;
  localparam int ST_PER      = 2;
  localparam int ST_ORER     = 3;
  localparam int ST_BRK      = 4;
  localparam int QC_LOOP     = 0;
  localparam int QC_RXFLUSH  = 1;
  localparam int QC_TXFLUSH  = 2;
  localparam int QC_HALTEN   = 3;
  localparam int FILL_TX_LSB = 8;

  //****************************************************************
  // reset values and counts
  //****************************************************************
  localparam logic [7:0] STOP_RST    = 8'hFF;
  localparam logic [7:0] DIV_RST     = 8'h35;
  localparam logic [6:0] QDEPTH      = 7'h40;
  localparam logic [3:0] OS_MID      = 4'h7;
  localparam logic [3:0] OS_LAST     = 4'hF;
  localparam logic [2:0] BIT_LAST8   = 3'h7;
  localparam logic [2:0] BIT_LAST7   = 3'h6;

  //****************************************************************
  // types
  //****************************************************************
  typedef enum logic [5:0] {
    S_IDLE  = 6'h01,
    S_START = 6'h02,
    S_DATA  = 6'h04,
    S_PAR   = 6'h08,
    S_STOP  = 6'h10,
    S_BRK   = 6'h20
  } qsp_ser_e;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } qsp_req_s;

  typedef struct packed {
    logic [7:0]       mode;
    logic [7:0]       ctrl;
    logic [3:0]       qctl;
    logic [7:0]       stop_cnt;
    logic [7:0]       div;
    logic [4:0]       sts;
    logic [63:0][7:0] txq;
    logic [63:0][7:0] rxq;
    logic [5:0]       tx_wr;
    logic [5:0]       tx_rd;
    logic [6:0]       tx_cnt;
    logic [5:0]       rx_wr;
    logic [5:0]       rx_rd;
    logic [6:0]       rx_cnt;
    logic             rxd_s1;
    logic             rxd_s2;
    logic             cts_s1;
    logic             cts_s2;
    logic             sck_s1;
    logic             sck_s2;
    logic             sck_d;
    logic [7:0]       div_cnt;
    qsp_ser_e         tx_st;
    logic [3:0]       tx_os;
    logic [2:0]       tx_bit;
    logic [7:0]       tx_sh;
    logic             tx_par;
    logic             tx_stp;
    logic             tx_line;
    logic [7:0]       sent;
    qsp_ser_e         rx_st;
    logic [3:0]       rx_os;
    logic [2:0]       rx_bit;
    logic [7:0]       rx_sh;
    logic             rx_par;
    logic             rts_int_n;
    logic             txd;
    logic             rts_n;
    logic             irq;
    logic [15:0]      rdata;
  } qsp_state_s;

endpackage

/* logic/qsp_queue_port.sv */
// module: queued asynchronous serial port with register port, queues and frame logic
`timescale 1ns/100ps

module qsp_queue_port
  import qsp_pkg::*;
(
  input  wire logic     mclk,
  input  wire logic     rst,
  input  wire logic     ce,
  input  wire qsp_req_s req,
  output logic [15:0]   rdata,
  input  wire logic     rxd,
  input  wire logic     cts_n,
  input  wire logic     sclk,
  output logic          txd,
  output logic          rts_n,
  output logic          tx_halt_irq
);

  qsp_state_s s_r;
  qsp_state_s s_nxt;

  assign rdata       = s_r.rdata;
  assign txd         = s_r.txd;
  assign rts_n       = s_r.rts_n;
  assign tx_halt_irq = s_r.irq;

  //****************************************************************
  // next state
  //****************************************************************
  always_comb begin
    logic       rx_line;
    logic       cts_on;
    logic       tick;
    logic       tx_push;
    logic       tx_pop;
    logic       rx_push;
    logic       rx_pop;
    logic [2:0] last_bit;
    logic [7:0] dmask;
    logic       rx_perr;
    rx_line  = 1'b1;
    cts_on   = 1'b0;
    tick     = 1'b0;
    tx_push  = 1'b0;
    tx_pop   = 1'b0;
    rx_push  = 1'b0;
    rx_pop   = 1'b0;
    last_bit = BIT_LAST8;
    dmask    = 8'hFF;
    rx_perr  = 1'b0;
    s_nxt    = s_r;

    // pin synchronisers
    s_nxt.rxd_s1 = rxd;
    s_nxt.rxd_s2 = s_r.rxd_s1;
    s_nxt.cts_s1 = cts_n;
    s_nxt.cts_s2 = s_r.cts_s1;
    s_nxt.sck_s1 = sclk;
    s_nxt.sck_s2 = s_r.sck_s1;
    s_nxt.sck_d  = s_r.sck_s2;

    // internal loopback paths
    if (s_r.qctl[QC_LOOP]) begin
      rx_line = s_r.tx_line;
      cts_on  = ~s_r.rts_int_n;
    end else begin
      rx_line = s_r.rxd_s2;
      cts_on  = ~s_r.cts_s2;
    end

    // oversample tick: external clock edges or internal divider
    if (s_r.ctrl[CTRL_CKS_HI]) begin
      tick = s_r.sck_s2 ^ s_r.sck_d;
      s_nxt.div_cnt = 8'h00;
    end else if (s_r.div_cnt == s_r.div) begin
      tick = 1'b1;
      s_nxt.div_cnt = 8'h00;
    end else begin
      s_nxt.div_cnt = s_r.div_cnt + 8'h01;
    end

    if (s_r.mode[MODE_CHR]) begin
      last_bit = BIT_LAST7;
      dmask    = 8'h7F;
    end

    //****************************************************************
    // register writes
    //****************************************************************
    if (req.wr) begin
      case (req.addr)
        REG_MODE: s_nxt.mode = req.wdata[7:0];
        REG_CTRL: s_nxt.ctrl = req.wdata[7:0];
        REG_STAT: s_nxt.sts = s_r.sts & req.wdata[4:0];
        REG_DATA: begin
          if (!s_r.qctl[QC_TXFLUSH] && s_r.tx_cnt != QDEPTH) begin
            tx_push = 1'b1;
          end
        end
        REG_QCTL: s_nxt.qctl = req.wdata[3:0];
        REG_STOP: s_nxt.stop_cnt = req.wdata[7:0];
        REG_DIV:  s_nxt.div = req.wdata[7:0];
        default:  s_nxt.div = s_r.div;
      endcase
      if (req.addr == REG_STAT && !req.wdata[ST_HALT]) begin
        s_nxt.sent = 8'h00;
      end
    end

    //****************************************************************
    // register reads, data valid the next cycle only
    //****************************************************************
    s_nxt.rdata = 16'h0000;
    if (req.rd) begin
      case (req.addr)
        REG_MODE: s_nxt.rdata = {8'h00, s_r.mode};
        REG_CTRL: s_nxt.rdata = {8'h00, s_r.ctrl};
        REG_STAT: s_nxt.rdata = {8'h00, (s_r.tx_st == S_IDLE && s_r.tx_cnt == 7'h00),
                                 (s_r.rx_cnt != 7'h00), (s_r.rx_cnt == QDEPTH),
                                 s_r.sts};
        REG_DATA: begin
          s_nxt.rdata = {8'h00, s_r.rxq[s_r.rx_rd]};
          rx_pop = (s_r.rx_cnt != 7'h00);
        end
        REG_QCTL: s_nxt.rdata = {12'h000, s_r.qctl};
        REG_FILL: s_nxt.rdata = {1'b0, s_r.tx_cnt, 1'b0, s_r.rx_cnt};
        REG_STOP: s_nxt.rdata = {8'h00, s_r.stop_cnt};
        REG_DIV:  s_nxt.rdata = {8'h00, s_r.div};
        default:  s_nxt.rdata = 16'h0000;
      endcase
    end

    //****************************************************************
    // transmitter
    //****************************************************************
    if (!s_r.ctrl[CTRL_TXEN]) begin
      s_nxt.tx_st   = S_IDLE;
      s_nxt.tx_line = 1'b1;
    end else begin
      case (s_r.tx_st)
        S_IDLE: begin
          s_nxt.tx_line = 1'b1;
          if (tick && s_r.tx_cnt != 7'h00 && cts_on && !s_r.sts[ST_HALT] &&
              !s_r.qctl[QC_TXFLUSH]) begin
            tx_pop        = 1'b1;
            s_nxt.tx_sh   = s_r.txq[s_r.tx_rd] & dmask;
            s_nxt.tx_par  = (^(s_r.txq[s_r.tx_rd] & dmask)) ^ s_r.mode[MODE_ODD];
            s_nxt.tx_os   = 4'h0;
            s_nxt.tx_st   = S_START;
            s_nxt.tx_line = 1'b0;
          end
        end
        S_START, S_DATA, S_PAR, S_STOP: begin
          if (tick) begin
            s_nxt.tx_os = s_r.tx_os + 4'h1;
            if (s_r.tx_os == OS_LAST) begin
              case (s_r.tx_st)
                S_START: begin
                  s_nxt.tx_st   = S_DATA;
                  s_nxt.tx_bit  = 3'h0;
                  s_nxt.tx_line = s_r.tx_sh[0];
                end
                S_DATA: begin
                  if (s_r.tx_bit == last_bit) begin
                    s_nxt.tx_stp = 1'b0;
                    if (s_r.mode[MODE_PAR]) begin
                      s_nxt.tx_st   = S_PAR;
                      s_nxt.tx_line = s_r.tx_par;
                    end else begin
                      s_nxt.tx_st   = S_STOP;
                      s_nxt.tx_line = 1'b1;
                    end
                  end else begin
                    s_nxt.tx_bit  = s_r.tx_bit + 3'h1;
                    s_nxt.tx_sh   = {1'b0, s_r.tx_sh[7:1]};
                    s_nxt.tx_line = s_r.tx_sh[1];
                  end
                end
                S_PAR: begin
                  s_nxt.tx_st   = S_STOP;
                  s_nxt.tx_line = 1'b1;
                end
                default: begin
                  if (s_r.mode[MODE_STOP2] && !s_r.tx_stp) begin
                    s_nxt.tx_stp = 1'b1;
                  end else begin
                    s_nxt.tx_st = S_IDLE;
                    if (s_r.qctl[QC_HALTEN] && !s_r.mode[MODE_SYNC]) begin
                      if (s_r.sent == s_r.stop_cnt) begin
                        s_nxt.sts[ST_HALT] = 1'b1;
                        s_nxt.sent = 8'h00;
                      end else begin
                        s_nxt.sent = s_r.sent + 8'h01;
                      end
                    end
                  end
                end
              endcase
            end
          end
        end
        default: begin
          s_nxt.tx_st   = S_IDLE;
          s_nxt.tx_line = 1'b1;
        end
      endcase
    end

    //****************************************************************
    // receiver
    //****************************************************************
    if (!s_r.ctrl[CTRL_RXEN]) begin
      s_nxt.rx_st = S_IDLE;
    end else if (tick) begin
      s_nxt.rx_os = s_r.rx_os + 4'h1;
      case (s_r.rx_st)
        S_IDLE: begin
          s_nxt.rx_os = 4'h0;
          if (!rx_line) begin
            s_nxt.rx_st = S_START;
          end
        end
        S_START: begin
          if (s_r.rx_os == OS_MID) begin
            s_nxt.rx_os  = 4'h0;
            s_nxt.rx_bit = 3'h0;
            s_nxt.rx_sh  = 8'h00;
            s_nxt.rx_st  = rx_line ? S_IDLE : S_DATA;
          end
        end
        S_DATA: begin
          if (s_r.rx_os == OS_LAST) begin
            s_nxt.rx_sh[s_r.rx_bit] = rx_line;
            s_nxt.rx_bit = s_r.rx_bit + 3'h1;
            if (s_r.rx_bit == last_bit) begin
              s_nxt.rx_par = 1'b0;
              s_nxt.rx_st  = s_r.mode[MODE_PAR] ? S_PAR : S_STOP;
            end
          end
        end
        S_PAR: begin
          if (s_r.rx_os == OS_LAST) begin
            s_nxt.rx_par = rx_line;
            s_nxt.rx_st  = S_STOP;
          end
        end
        S_STOP: begin
          if (s_r.rx_os == OS_LAST) begin
            // only the first stop bit is checked
            rx_perr = s_r.mode[MODE_PAR] &&
                      ((^s_r.rx_sh) ^ s_r.mode[MODE_ODD] ^ s_r.rx_par);
            s_nxt.rx_st = S_IDLE;
            if (!rx_line && s_r.rx_sh == 8'h00 && !s_r.rx_par) begin
              s_nxt.sts[ST_BRK] = 1'b1;
              s_nxt.sts[ST_FER] = 1'b1;
              s_nxt.rx_st = S_BRK;
            end else begin
              if (!rx_line) begin
                s_nxt.sts[ST_FER] = 1'b1;
              end
              if (rx_perr) begin
                s_nxt.sts[ST_PER] = 1'b1;
              end
              if (s_r.qctl[QC_RXFLUSH]) begin
                rx_push = 1'b0;
              end else if (s_r.rx_cnt == QDEPTH && !rx_pop) begin
                s_nxt.sts[ST_ORER] = 1'b1;
              end else begin
                rx_push = 1'b1;
              end
            end
          end
        end
        S_BRK: begin
          if (rx_line) begin
            s_nxt.rx_st = S_IDLE;
          end
        end
        default: s_nxt.rx_st = S_IDLE;
      endcase
    end

    //****************************************************************
    // queues
    //****************************************************************
    if (tx_push) begin
      s_nxt.txq[s_r.tx_wr] = req.wdata[7:0];
      s_nxt.tx_wr = s_r.tx_wr + 6'h01;
    end
    if (tx_pop) begin
      s_nxt.tx_rd = s_r.tx_rd + 6'h01;
    end
    s_nxt.tx_cnt = s_r.tx_cnt + {6'h00, tx_push} - {6'h00, tx_pop};
    if (rx_push) begin
      s_nxt.rxq[s_r.rx_wr] = s_r.rx_sh & dmask;
      s_nxt.rx_wr = s_r.rx_wr + 6'h01;
    end
    if (rx_pop) begin
      s_nxt.rx_rd = s_r.rx_rd + 6'h01;
    end
    s_nxt.rx_cnt = s_r.rx_cnt + {6'h00, rx_push} - {6'h00, rx_pop};
    if (s_r.qctl[QC_TXFLUSH]) begin
      s_nxt.tx_wr  = 6'h00;
      s_nxt.tx_rd  = 6'h00;
      s_nxt.tx_cnt = 7'h00;
    end
    if (s_r.qctl[QC_RXFLUSH]) begin
      s_nxt.rx_wr  = 6'h00;
      s_nxt.rx_rd  = 6'h00;
      s_nxt.rx_cnt = 7'h00;
    end

    //****************************************************************
    // pins and request
    //****************************************************************
    s_nxt.rts_int_n = (s_r.rx_cnt == QDEPTH);
    s_nxt.txd   = s_nxt.qctl[QC_LOOP] ? 1'b1 : s_nxt.tx_line;
    s_nxt.rts_n = s_nxt.qctl[QC_LOOP] ? 1'b1 : s_nxt.rts_int_n;
    s_nxt.irq   = s_nxt.sts[ST_HALT] & s_nxt.ctrl[CTRL_HALTIE];
  end

  //****************************************************************
  // state register
  //****************************************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_r           <= '0;
      s_r.stop_cnt  <= STOP_RST;
      s_r.div       <= DIV_RST;
      s_r.rxd_s1    <= 1'b1;
      s_r.rxd_s2    <= 1'b1;
      s_r.cts_s1    <= 1'b1;
      s_r.cts_s2    <= 1'b1;
      s_r.tx_st     <= S_IDLE;
      s_r.rx_st     <= S_IDLE;
      s_r.tx_line   <= 1'b1;
      s_r.txd       <= 1'b1;
      s_r.rts_n     <= 1'b1;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

endmodule

/* tb/qsp_far_end.sv */
// far-end model: remote asynchronous transceiver on the serial pins
`timescale 1ns/100ps

module qsp_far_end #(
  parameter int BIT_CYC = 16
) (
  input  wire logic mclk,
  input  wire logic txd,
  input  wire logic rts_n,
  output logic      rxd,
  output logic      cts_n
);
  //****************************************************************
  // frame capture and frame sending
  //****************************************************************
  logic [8:0] got[$];
  logic [8:0] cap;

  initial begin
    rxd   = 1'b1;
    cts_n = 1'b0;
  end

  // mid-bit samples: eight data bits lsb first, then parity or stop
  initial forever begin
    @(posedge mclk);
    if (txd === 1'b0) begin
      repeat (BIT_CYC / 2) @(posedge mclk);
      for (int i = 0; i < 9; i++) begin
        repeat (BIT_CYC) @(posedge mclk);
        cap[i] = txd;
      end
      got.push_back(cap);
      repeat (BIT_CYC / 2 + 1) @(posedge mclk);
    end
  end

  // sends 8N1 only if the port asks for data when the frame starts
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    if (rts_n === 1'b0) begin
      for (int i = 0; i < 10; i++) begin
        rxd <= f[i];
        repeat (BIT_CYC) @(posedge mclk);
      end
    end
  endtask
endmodule

/* tb/qsp_queue_port_monitor.sv */
// checker: port-level properties of the queued serial port
`timescale 1ns/100ps

module qsp_queue_port_monitor
  import qsp_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        ce,
  input wire qsp_req_s    req,
  input wire logic [15:0] rdata,
  input wire logic        rxd,
  input wire logic        txd,
  input wire logic        rts_n,
  input wire logic        tx_halt_irq
);
  //****************************************************************
  // shadow of the control bits software has written
  //****************************************************************
  logic       loop_r;
  logic       rxf_r;
  logic       txf_r;
  logic       hie_r;
  logic       fresh_r;
  logic [7:0] stop_r;
  logic       rd_fill;

  assign rd_fill = ce && req.rd && (req.addr == REG_FILL);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      {txf_r, rxf_r, loop_r, hie_r} <= 4'h0;
      stop_r  <= STOP_RST;
      fresh_r <= 1'b1;
    end else begin
      if (!rxd || (ce && req.wr && req.addr == REG_DATA)) begin
        fresh_r <= 1'b0;
      end
      if (ce && req.wr && req.addr == REG_QCTL) begin
        {txf_r, rxf_r, loop_r} <= req.wdata[2:0];
      end
      if (ce && req.wr && req.addr == REG_CTRL) begin
        hie_r <= req.wdata[CTRL_HALTIE];
      end
      if (ce && req.wr && req.addr == REG_STOP) begin
        stop_r <= req.wdata[7:0];
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_fill_rsvd: assert property (rd_fill |=> !rdata[15] && !rdata[7])
    else $error("fill count reserved bit set");
  a_fill_range: assert property (rd_fill |=> rdata[14:8] <= 7'h40 && rdata[6:0] <= 7'h40)
    else $error("fill count above queue depth");
  a_fill_fresh: assert property (rd_fill && fresh_r |=> rdata == 16'h0000)
    else $error("queues not empty after reset");
  a_txq_flushed: assert property (rd_fill && txf_r && $past(txf_r, 3) |=> rdata[14:8] == 7'h00)
    else $error("tx queue not empty under flush");
  a_rxq_flushed: assert property (rd_fill && rxf_r && $past(rxf_r, 3) |=> rdata[6:0] == 7'h00)
    else $error("rx queue not empty under flush");
  a_loop_quiet: assert property (loop_r && $past(loop_r, 2) |-> txd && rts_n)
    else $error("pins not parked during loopback");
  a_irq_gate: assert property (tx_halt_irq |-> hie_r)
    else $error("halt request without enable");
  a_stop_value: assert property (ce && req.rd && req.addr == REG_STOP |=> rdata[7:0] == $past(stop_r))
    else $error("stop count read back wrong");
endmodule

bind qsp_queue_port qsp_queue_port_monitor i_qsp_queue_port_monitor (
  .mclk(mclk), .rst(rst), .ce(ce), .req(req), .rdata(rdata), .rxd(rxd),
  .txd(txd), .rts_n(rts_n), .tx_halt_irq(tx_halt_irq));

/* tb/qsp_queue_port_tb.sv */
// testbench: register port, queues, framing, halt and loopback scenarios
`timescale 1ns/100ps

module qsp_queue_port_tb;
  import qsp_pkg::*;
  //****************************************************************
  // harness
  //****************************************************************
  logic        mclk;
  logic        rst;
  logic        ce;
  qsp_req_s    req;
  logic [15:0] rdata;
  logic        rxd;
  logic        cts_n;
  logic        sclk = 1'b0;
  logic        txd;
  logic        rts_n;
  logic        tx_halt_irq;
  int          num_errors = 0;
  int          checked = 0;

  qsp_queue_port i_qsp_queue_port (.mclk(mclk), .rst(rst), .ce(ce), .req(req),
    .rdata(rdata), .rxd(rxd), .cts_n(cts_n), .sclk(sclk), .txd(txd), .rts_n(rts_n),
    .tx_halt_irq(tx_halt_irq));
  qsp_far_end i_qsp_far_end (.mclk(mclk), .txd(txd), .rts_n(rts_n), .rxd(rxd),
    .cts_n(cts_n));

  always #5 mclk = ~mclk;

  // free-running external serial clock: eight periods per sixteen-cycle bit
  always @(posedge mclk) sclk <= ~sclk;

  task automatic end_sim();
    $display("checked=%0d num_errors=%0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    req <= '0;
  endtask

  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge mclk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge mclk);
    req <= '0;
    #1 d = rdata;
  endtask

  task automatic poll(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e);
    logic [15:0] v;
    int          n;
    for (n = 0; n < 600; n++) begin
      rd(a, v);
      if ((v & m) === e) return;
    end
    num_errors++;
    end_sim();
  endtask

  task automatic wait_got(input int n);
    int k;
    for (k = 0; k < 3000 && i_qsp_far_end.got.size() < n; k++) @(posedge mclk);
    if (k >= 3000) begin
      num_errors++;
      end_sim();
    end
  endtask

  //****************************************************************
  // scenarios
  //****************************************************************
  task automatic t_reset();
    logic [15:0] v;
    rd(REG_FILL, v);
    chk(v, 16'h0000);
    rd(REG_STOP, v);
    chk(v, {8'h00, STOP_RST});
  endtask

  task automatic t_fill();
    logic [15:0] v;
    for (int i = 0; i < 65; i++) wr(REG_DATA, 16'h0011);
    rd(REG_FILL, v);
    chk(v, {1'b0, QDEPTH, 8'h00});
    wr(REG_FILL, 16'hFFFF);
    rd(REG_FILL, v);
    chk(v, 16'h4000);
    wr(REG_QCTL, 16'h0004);
    wr(REG_DATA, 16'h0022);
    rd(REG_FILL, v);
    chk(v, 16'h0000);
    wr(REG_QCTL, 16'h0000);
  endtask

  task automatic t_frame();
    logic [15:0] v;
    wr(REG_DIV, 16'h0000);
    wr(REG_STOP, 16'h0000);
    wr(REG_QCTL, 16'h0008);
    wr(REG_MODE, 16'h0080);
    wr(REG_CTRL, 16'h0020);
    wr(REG_DATA, 16'h00A5);
    wait_got(1);
    chk({7'h00, i_qsp_far_end.got.pop_front()}, 16'h01A5);
    // let the stop bit finish before the format changes
    repeat (16) @(posedge mclk);
    wr(REG_MODE, 16'h0038);
    wr(REG_DATA, 16'h0003);
    wait_got(1);
    chk({7'h00, i_qsp_far_end.got.pop_front()}, 16'h0103);
    // second stop bit still on the line: busy, no halt yet
    repeat (32) @(posedge mclk);
    rd(REG_STAT, v);
    chk(v, 16'h0000);
    repeat (8) @(posedge mclk);
    rd(REG_STAT, v);
    chk(v, 16'h0081);
    wr(REG_STAT, 16'h0000);
    wr(REG_QCTL, 16'h0000);
    wr(REG_MODE, 16'h0000);
  endtask

  task automatic t_halt();
    logic [15:0] v;
    int          n;
    wr(REG_STOP, 16'h0001);
    rd(REG_STOP, v);
    chk(v, 16'h0001);
    wr(REG_QCTL, 16'h0008);
    wr(REG_CTRL, 16'h0024);
    for (int i = 0; i < 4; i++) wr(REG_DATA, 16'h0050 + i[15:0]);
    for (n = 0; n < 3000 && tx_halt_irq !== 1'b1; n++) @(posedge mclk);
    chk({15'h0000, tx_halt_irq}, 16'h0001);
    // one full frame time: nothing more may start
    repeat (200) @(posedge mclk);
    chk(16'(i_qsp_far_end.got.size()), 16'h0002);
    rd(REG_FILL, v);
    chk(v, 16'h0200);
    i_qsp_far_end.got.delete();
    wr(REG_QCTL, 16'h0004);
    wr(REG_STAT, 16'h0000);
    wr(REG_CTRL, 16'h0000);
    wr(REG_QCTL, 16'h0000);
    chk({15'h0000, tx_halt_irq}, 16'h0000);
  endtask

  task automatic t_loop();
    logic [15:0] v;
    wr(REG_MODE, 16'h0040);
    wr(REG_QCTL, 16'h0001);
    wr(REG_CTRL, 16'h0030);
    wr(REG_DATA, 16'h00FF);
    wr(REG_DATA, 16'h0080);
    poll(REG_FILL, 16'h007F, 16'h0002);
    rd(REG_DATA, v);
    chk({8'h00, v[7:0]}, 16'h007F);
    chk(16'(i_qsp_far_end.got.size()), 16'h0000);
    wr(REG_QCTL, 16'h0003);
    repeat (2) @(posedge mclk);
    rd(REG_FILL, v);
    chk(v, 16'h0000);
    wr(REG_QCTL, 16'h0000);
    wr(REG_MODE, 16'h0000);
  endtask

  task automatic t_rx_far();
    logic [15:0] v;
    // slow divider: only the external clock gives the right bit time
    wr(REG_DIV, 16'h0035);
    wr(REG_CTRL, 16'h0012);
    i_qsp_far_end.send(8'h3C);
    poll(REG_FILL, 16'h007F, 16'h0001);
    rd(REG_STAT, v);
    chk(v, 16'h00C0);
    rd(REG_DATA, v);
    chk({8'h00, v[7:0]}, 16'h003C);
  endtask

  initial begin
    mclk = 1'b0;
    rst  = 1'b1;
    ce   = 1'b1;
    req  = '0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_fill();
    t_frame();
    t_halt();
    t_loop();
    t_rx_far();
    end_sim();
  end
endmodule
